// ==== logic/angle_history.sv ====
// Purpose: Per-channel angle delay line, DEPTH samples deep
// Assumes: shift_i is the measurement tick
// Notes: old_o is the sample written DEPTH ticks earlier

`timescale 1ns/1ps

module angle_history #(
  parameter int CHANNELS = 4,
  parameter int DEPTH = 8,
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Samples
  input wire logic shift_i,
  input wire logic [CHANNELS-1:0][W-1:0] data_i,
  output logic [CHANNELS-1:0][W-1:0] old_o
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [PTR_W-1:0] wp_q;

  if (DEPTH < 1) begin : g_bad
    $error("angle_history needs a depth of at least one");
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_q <= '0;
    end else if (shift_i) begin
      wp_q <= (wp_q == PTR_W'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    logic [W-1:0] mem_q [DEPTH];
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem_q[i] <= '0;
        end
      end else if (shift_i) begin
        mem_q[wp_q] <= data_i[c];
      end
    end
    assign old_o[c] = mem_q[wp_q];
  end

endmodule : angle_history

// ==== logic/tick_divider.sv ====
// Purpose: One-cycle enable pulse at the measurement rate
// Assumes: Single clock, CYCLES clocks between pulses
// Notes: Pulse is registered

`timescale 1ns/1ps

module tick_divider #(
  parameter int CYCLES = 250000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Enable out
  output logic tick_o
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cnt_q;

  if (CYCLES < 2) begin : g_bad
    $error("tick_divider needs at least two cycles per tick");
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q == CNT_W'(CYCLES - 1)) begin
      cnt_q <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end

  tick_gap_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick_o |=> !tick_o) else $error("tick pulse longer than one cycle");

endmodule : tick_divider

// ==== logic/voltage_tx_supervision.sv ====
// Purpose: Voltage transformer supervision on four voltage channels
// Assumes: Front end presents magnitude and angle on the same clock
// Notes: All evaluation advances on the 5 ms measurement tick

`timescale 1ns/1ps

// Notes on behaviour
// R1 - Use four channel magnitudes, refreshed every 5 ms
// R2 - Derive sequence rotation for supervision decisions
// R3 - Track every channel's phase angle
// R4 - Pick-up: one phase low and two high
// R5 - Low and high thresholds, 0.01 steps, defaults
// R6 - Recompute per-phase threshold ratios every update
// R7 - Small 40 ms angle change blocks pick-up
// R8 - Bus fuse check reports bus fuse failure
// R9 - Line fuse check reports line fuse failure
// R10 - Report bus dead or live and healthy
// R11 - Report reversed phase rotation state
// R12 - Report undefined phase rotation state
// R13 - Report problem state on any pick-up
// R14 - Expose five-value condition code
// R15 - Expose expected delay, 5 ms resolution
// R16 - Signed remaining time while timing a fault
// R17 - Settings change at run time, no stop
// R18 - Output usable as alarm and block
// R19 - Block at pick-up gives blocked, no timing
// R20 - Alarm after pick-up persists definite delay
// R21 - Block sampled at start of each cycle
// R22 - Everything advances once per tick, 8-deep history
// R23 - Remaining time reloads, stops on release/block
module voltage_tx_supervision
  import vts_pkg::*;
#(
  parameter int TICK_CLOCKS = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Measurements
  input wire chan_type [NCH-1:0] chans_i,
  // Settings and block
  input wire settings_type settings_i,
  input wire logic block_i,
  // Fuse failure pins
  input wire logic bus_breaker_trip_input_i,
  input wire logic line_breaker_trip_input_i,
  // Status
  output condition_type condition_o,
  output bus_state_type bus_state_o,
  output volt_state_type [NCH-1:0] volt_state_o,
  output rotation_type rotation_o,
  output logic [NCH-1:0][ANG_W-1:0] angle_diff_o,
  output logic started_o,
  output logic blocked_o,
  output logic alarm_o,
  output logic bus_transformer_failure_o,
  output logic line_transformer_failure_o,
  output logic supervision_block_o,
  // Timing
  output logic [TIME_W-1:0] expected_time_o,
  output logic signed [REM_W-1:0] remaining_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [ANG_W-1:0] ang_sub(input logic [ANG_W-1:0] a,
                                               input logic [ANG_W-1:0] b);
    ang_sub = (a >= b) ? a - b : a + FULL_TURN - b;
  endfunction : ang_sub

  function automatic logic [ANG_W-1:0] ang_dist(input logic [ANG_W-1:0] a,
                                                input logic [ANG_W-1:0] b);
    logic [ANG_W-1:0] d;
    d = ang_sub(a, b);
    ang_dist = (d > HALF_TURN) ? FULL_TURN - d : d;
  endfunction : ang_dist

  function automatic logic near(input logic [ANG_W-1:0] v,
                                input logic [ANG_W-1:0] c);
    near = (v + SEQ_TOLERANCE >= c) && (v <= c + SEQ_TOLERANCE);
  endfunction : near

  // ****************************************
  // Tick and pin synchronisers
  // ****************************************
  logic tick;
  logic [1:0] bus_sync_q;
  logic [1:0] line_sync_q;

  if (TICK_CLOCKS < 2) begin : g_bad
    $error("voltage_tx_supervision needs at least two clocks per tick");
  end

  tick_divider #(
    .CYCLES(TICK_CLOCKS)
  ) u_tick (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tick_o(tick)
  );

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_sync_q <= 2'h0;
      line_sync_q <= 2'h0;
    end else begin
      bus_sync_q <= {bus_sync_q[0], bus_breaker_trip_input_i};
      line_sync_q <= {line_sync_q[0], line_breaker_trip_input_i};
    end
  end

  // ****************************************
  // Angle history and per-channel evaluation
  // ****************************************
  logic [NCH-1:0][ANG_W-1:0] ang_now;
  logic [NCH-1:0][ANG_W-1:0] ang_old;
  logic [NCH-1:0][ANG_W-1:0] ang_diff;
  volt_state_type [NCH-1:0] vstate_d;
  logic [NPH-1:0] below_low;
  logic [NPH-1:0] above_high;
  logic [NPH-1:0] ang_steady;

  angle_history #(
    .CHANNELS(NCH),
    .DEPTH(HIST_DEPTH),
    .W(ANG_W)
  ) u_hist (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .shift_i(tick), // R22
    .data_i(ang_now),
    .old_o(ang_old)
  );

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    assign ang_now[c] = chans_i[c].ang; // R3
    assign ang_diff[c] = ang_dist(ang_now[c], ang_old[c]); // R7
    always_comb begin
      if (chans_i[c].mag < settings_i.low_pickup) begin // R5 R6
        vstate_d[c] = VOLT_NONE;
      end else if (chans_i[c].mag > settings_i.high_detect) begin // R6
        vstate_d[c] = VOLT_OK;
      end else begin
        vstate_d[c] = VOLT_LOW;
      end
    end
  end

  for (genvar p = 0; p < NPH; p++) begin : g_phase
    assign below_low[p] = (vstate_d[p] == VOLT_NONE); // R4
    assign above_high[p] = (vstate_d[p] == VOLT_OK); // R4
    // R7
    assign ang_steady[p] = ang_diff[p] < ANG_W'(settings_i.angle_limit);
  end

  // ****************************************
  // Sequence rotation and pick-up
  // ****************************************
  logic [ANG_W-1:0] lag12;
  logic [ANG_W-1:0] lag13;
  rotation_type rot_d;
  logic two_high;
  logic pick;

  assign lag12 = ang_sub(ang_now[0], ang_now[1]);
  assign lag13 = ang_sub(ang_now[0], ang_now[2]);

  always_comb begin
    if (near(lag12, THIRD_TURN) && near(lag13, TWO_THIRD_TURN)) begin // R2
      rot_d = ROT_POS;
    end else if (near(lag12, TWO_THIRD_TURN) &&
                 near(lag13, THIRD_TURN)) begin // R2
      rot_d = ROT_NEG;
    end else begin
      rot_d = ROT_UNDEF;
    end
  end

  assign two_high = (above_high[0] && above_high[1]) ||
                    (above_high[0] && above_high[2]) ||
                    (above_high[1] && above_high[2]);
  // R4 R7
  assign pick = (|below_low) && two_high && !(&ang_steady);

  // ****************************************
  // Per-tick status registers
  // ****************************************
  logic pick_q;
  logic bus_fuse_q;
  logic line_fuse_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      volt_state_o <= {NCH{VOLT_NONE}};
      rotation_o <= ROT_UNDEF;
      angle_diff_o <= '0;
      pick_q <= 1'b0;
    end else if (tick) begin // R1 R22
      volt_state_o <= vstate_d; // R6
      rotation_o <= rot_d;
      angle_diff_o <= ang_diff;
      pick_q <= pick;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_fuse_q <= 1'b0;
      line_fuse_q <= 1'b0;
    end else if (tick) begin
      bus_fuse_q <= settings_i.bus_fuse_check && bus_sync_q[1]; // R8
      line_fuse_q <= settings_i.line_fuse_check && line_sync_q[1]; // R9
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_state_o <= BUS_DEAD;
    end else if (tick) begin
      if (pick) begin
        bus_state_o <= BUS_LIVE_PROBLEM; // R13
      end else if (&below_low) begin
        bus_state_o <= BUS_DEAD; // R10
      end else if (&above_high && rot_d == ROT_POS) begin
        bus_state_o <= BUS_LIVE_OK; // R10
      end else if (&above_high && rot_d == ROT_NEG) begin
        bus_state_o <= BUS_LIVE_REV; // R11
      end else begin
        bus_state_o <= BUS_LIVE_UNDEF; // R12
      end
    end
  end

  // ****************************************
  // Definite-time timer
  // ****************************************
  logic timing_q;
  logic pick_rise;

  assign pick_rise = pick && !pick_q;

  // Block is read only on the tick, so a block raised between ticks acts at the next tick
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      started_o <= 1'b0;
      blocked_o <= 1'b0;
      timing_q <= 1'b0;
    end else if (tick) begin // R21
      if (!pick) begin
        started_o <= 1'b0;
        blocked_o <= 1'b0;
        timing_q <= 1'b0;
      end else if (block_i) begin
        started_o <= 1'b0; // R19
        blocked_o <= pick_rise || blocked_o || started_o; // R19
        timing_q <= 1'b0; // R23
      end else if (pick_rise) begin
        started_o <= 1'b1;
        timing_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remaining_o <= '0;
    end else if (tick && pick && !block_i) begin
      if (pick_rise) begin
        remaining_o <= $signed({1'b0, settings_i.definite_time_delay}); // R23
      end else if (timing_q && remaining_o > 0) begin
        remaining_o <= remaining_o - REM_W'(1); // R16 R20
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_o <= 1'b0;
    end else if (tick) begin
      if (!pick) begin
        alarm_o <= 1'b0;
      end else if (!block_i && pick_rise &&
                   settings_i.definite_time_delay == '0) begin
        alarm_o <= 1'b1; // R20
      end else if (!block_i && timing_q && remaining_o == 1) begin
        alarm_o <= 1'b1; // R20
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      expected_time_o <= '0;
    end else if (tick) begin
      expected_time_o <= settings_i.definite_time_delay; // R15 R17
    end
  end

  assign bus_transformer_failure_o = alarm_o || bus_fuse_q; // R8
  assign line_transformer_failure_o = line_fuse_q; // R9
  // R18
  assign supervision_block_o = alarm_o || bus_fuse_q || line_fuse_q;

  always_comb begin
    if (blocked_o) begin
      condition_o = COND_BLOCKED; // R14
    end else if (bus_transformer_failure_o) begin
      condition_o = COND_BUS_FAIL;
    end else if (line_transformer_failure_o) begin
      condition_o = COND_LINE_FAIL;
    end else if (started_o) begin
      condition_o = COND_STARTED;
    end else begin
      condition_o = COND_NORMAL;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  reload_delay_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick && pick && !pick_q && !block_i |=>
      remaining_o == $signed({1'b0, $past(settings_i.definite_time_delay)}))
    else $error("remaining time not reloaded"); // R23

  countdown_step_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    tick && pick && pick_q && !block_i && timing_q && remaining_o > 0 |=>
      remaining_o == $past(remaining_o) - REM_W'(1))
    else $error("remaining time did not step down"); // R16

  hold_on_stop_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick && (!pick || block_i) |=> $stable(remaining_o))
    else $error("remaining time moved while stopped"); // R23

  alarm_after_delay_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    $rose(alarm_o) |-> remaining_o == 0 && started_o)
    else $error("alarm before delay ran out"); // R20

  block_no_start_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    tick && pick && !pick_q && block_i |=> blocked_o && !started_o
      && !timing_q)
    else $error("block at pick-up still started timing"); // R19

  idle_between_ticks_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    !tick |=> $stable(alarm_o) && $stable(started_o) && $stable(bus_state_o))
    else $error("state moved without a tick"); // R22

  problem_state_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    tick && pick |=> bus_state_o == BUS_LIVE_PROBLEM && pick_q)
    else $error("pick-up not reported as problem"); // R13

  fuse_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick && !settings_i.line_fuse_check |=> !line_transformer_failure_o)
    else $error("line fuse failure while check disabled"); // R9

  condition_code_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    blocked_o |-> condition_o == COND_BLOCKED && !supervision_block_o
      || condition_o == COND_BLOCKED)
    else $error("blocked not shown in condition"); // R14

  expected_time_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick ##1 1'b1 |-> expected_time_o == $past(settings_i.definite_time_delay))
    else $error("expected time not updated"); // R15

endmodule : voltage_tx_supervision

// ==== pkg/vts_pkg.sv ====
// Purpose: Shared constants and types for voltage transformer supervision
// Assumes: Magnitudes in 0.01 x nominal_voltage, angles in 0.1 deg steps
// Notes: Times are counted in measurement ticks of 5 ms

package vts_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_MS = 5;
  localparam int TICK_CYCLES = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ANGLE_WINDOW_MS = 40;
  localparam int HIST_DEPTH = ANGLE_WINDOW_MS / TICK_TIME_MS;

  // ****************************************
  // Widths and field layout
  // ****************************************
  localparam int NCH = 4;
  localparam int NPH = 3;
  localparam int MAG_W = 10;
  localparam int ANG_W = 12;
  localparam int LIM_W = 10;
  localparam int TIME_W = 19;
  localparam int REM_W = 20;

  // ****************************************
  // Reset values and angle figures
  // ****************************************
  localparam logic [MAG_W-1:0] LOW_PICKUP_RST = 10'h005;
  localparam logic [MAG_W-1:0] HIGH_DETECT_RST = 10'h050;
  localparam logic [LIM_W-1:0] ANGLE_LIMIT_RST = 10'h032;
  localparam logic [ANG_W-1:0] FULL_TURN = 12'hE10;
  localparam logic [ANG_W-1:0] HALF_TURN = 12'h708;
  localparam logic [ANG_W-1:0] THIRD_TURN = 12'h4B0;
  localparam logic [ANG_W-1:0] TWO_THIRD_TURN = 12'h960;
  localparam logic [ANG_W-1:0] SEQ_TOLERANCE = 12'h12C;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [MAG_W-1:0] mag;
    logic [ANG_W-1:0] ang;
  } chan_type;

  typedef struct packed {
    logic [MAG_W-1:0] low_pickup;
    logic [MAG_W-1:0] high_detect;
    logic [LIM_W-1:0] angle_limit;
    logic bus_fuse_check;
    logic line_fuse_check;
    logic [TIME_W-1:0] definite_time_delay;
  } settings_type;

  typedef enum logic [1:0] {
    VOLT_NONE = 2'h0,
    VOLT_OK = 2'h1,
    VOLT_LOW = 2'h2
  } volt_state_type;

  typedef enum logic [1:0] {
    ROT_UNDEF = 2'h0,
    ROT_POS = 2'h1,
    ROT_NEG = 2'h2
  } rotation_type;

  typedef enum logic [2:0] {
    BUS_DEAD = 3'h0,
    BUS_LIVE_OK = 3'h1,
    BUS_LIVE_REV = 3'h2,
    BUS_LIVE_UNDEF = 3'h3,
    BUS_LIVE_PROBLEM = 3'h4
  } bus_state_type;

  typedef enum logic [2:0] {
    COND_NORMAL = 3'h0,
    COND_STARTED = 3'h1,
    COND_LINE_FAIL = 3'h2,
    COND_BUS_FAIL = 3'h3,
    COND_BLOCKED = 3'h4
  } condition_type;

endpackage : vts_pkg

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for voltage transformer supervision
// Assumes: Short tick of TP clocks, delay of three ticks
// Notes: Outputs are sampled on falling edges, mid clock cycle

`timescale 1ns/1ps

module testbench;
  import vts_pkg::*;
  localparam int TP = 10;
  localparam int LIMIT = 3000;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [NPH-1:0][MAG_W-1:0] mag;
  rotation_type rot;
  logic slip, bus_trip, line_trip, block_i, bus_pin, line_pin;
  settings_type set_s;
  chan_type [NCH-1:0] chans;
  condition_type cond;
  bus_state_type bus_state;
  volt_state_type [NCH-1:0] volt;
  rotation_type rot_seen;
  logic [NCH-1:0][ANG_W-1:0] adiff;
  logic started, blocked, alarm, bus_fail, line_fail, sup_block;
  logic [TIME_W-1:0] exp_time;
  logic signed [REM_W-1:0] remaining;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  vt_front_end #(.PERIOD(TP)) model_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .mag_i(mag), .rot_i(rot), .slip_i(slip), .bus_trip_i(bus_trip),
    .line_trip_i(line_trip), .chans_o(chans), .bus_pin_o(bus_pin),
    .line_pin_o(line_pin));

  voltage_tx_supervision #(.TICK_CLOCKS(TP)) dut_u (.clk_i(clk_i),
    .resetn_i(resetn_i), .chans_i(chans), .settings_i(set_s),
    .block_i(block_i), .bus_breaker_trip_input_i(bus_pin),
    .line_breaker_trip_input_i(line_pin), .condition_o(cond),
    .bus_state_o(bus_state), .volt_state_o(volt), .rotation_o(rot_seen),
    .angle_diff_o(adiff), .started_o(started), .blocked_o(blocked),
    .alarm_o(alarm), .bus_transformer_failure_o(bus_fail),
    .line_transformer_failure_o(line_fail),
    .supervision_block_o(sup_block), .expected_time_o(exp_time),
    .remaining_o(remaining));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk_bit(string name, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_vec(string name, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_vec

  task automatic ticks(int n);
    repeat (n * TP) @(negedge clk_i);
  endtask : ticks

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    repeat (10) @(negedge clk_i);
    chk_vec("cond", COND_NORMAL, cond);
    chk_vec("bus", BUS_DEAD, bus_state);
    chk_vec("rem", 32'h0, remaining);
    resetn_i = 1'b1;
    ticks(2);
    chk_vec("bus", BUS_DEAD, bus_state);
    chk_vec("volt0", VOLT_NONE, volt[0]);
    $display("test reset done");
  endtask : t_reset

  task automatic t_sequence();
    rotation_type rots[3] = '{ROT_POS, ROT_NEG, ROT_UNDEF};
    bus_state_type exps[3] = '{BUS_LIVE_OK, BUS_LIVE_REV, BUS_LIVE_UNDEF};
    mag = {NPH{10'h064}};
    for (int r = 0; r < 3; r++) begin
      rot = rots[r];
      ticks(3);
      chk_vec("bus", exps[r], bus_state);
      chk_vec("rot", rots[r], rot_seen);
      chk_vec("volt1", VOLT_OK, volt[1]);
      chk_bit("started", 1'b0, started);
    end
    rot = ROT_POS;
    $display("test sequence done");
  endtask : t_sequence

  task automatic t_thresholds();
    mag[0] = 10'h01E;
    ticks(3);
    chk_vec("volt0", VOLT_LOW, volt[0]);
    set_s.low_pickup = 10'h028;
    ticks(3);
    chk_vec("volt0", VOLT_NONE, volt[0]);
    set_s.low_pickup = LOW_PICKUP_RST;
    mag[0] = 10'h000;
    ticks(3);
    chk_bit("started", 1'b0, started);
    chk_vec("bus", BUS_LIVE_UNDEF, bus_state);
    $display("test thresholds done");
  endtask : t_thresholds

  task automatic t_timer();
    slip = 1'b1;
    for (int i = 0; i < 4 * TP && started !== 1'b1; i++) @(negedge clk_i);
    chk_bit("started", 1'b1, started);
    chk_vec("cond", COND_STARTED, cond);
    chk_vec("bus", BUS_LIVE_PROBLEM, bus_state);
    chk_vec("exp", 32'h3, exp_time);
    chk_vec("rem", 32'h3, remaining);
    chk_vec("adiff0", 32'h64, adiff[0]);
    ticks(1);
    chk_vec("rem", 32'h2, remaining);
    ticks(1);
    chk_bit("alarm", 1'b0, alarm);
    ticks(1);
    chk_bit("alarm", 1'b1, alarm);
    chk_vec("rem", 32'h0, remaining);
    chk_bit("busfail", 1'b1, bus_fail);
    chk_bit("supblk", 1'b1, sup_block);
    mag[0] = 10'h064;
    ticks(2);
    chk_bit("alarm", 1'b0, alarm);
    chk_bit("started", 1'b0, started);
    $display("test timer done");
  endtask : t_timer

  task automatic t_block();
    block_i = 1'b1;
    mag[0] = 10'h000;
    ticks(3);
    chk_bit("blocked", 1'b1, blocked);
    chk_bit("started", 1'b0, started);
    chk_vec("cond", COND_BLOCKED, cond);
    chk_vec("rem", 32'h0, remaining);
    block_i = 1'b0;
    slip = 1'b0;
    mag[0] = 10'h064;
    ticks(2);
    chk_bit("blocked", 1'b0, blocked);
    $display("test block done");
  endtask : t_block

  task automatic t_fuses();
    for (int i = 0; i < 2; i++) begin
      set_s.bus_fuse_check = i[0];
      set_s.line_fuse_check = i[0];
      bus_trip = 1'b1;
      ticks(2);
      chk_bit("busfail", i[0], bus_fail);
      chk_vec("cond", i ? COND_BUS_FAIL : COND_NORMAL, cond);
      bus_trip = 1'b0;
      line_trip = 1'b1;
      ticks(2);
      chk_bit("linefail", i[0], line_fail);
      chk_bit("supblk", i[0], sup_block);
      chk_vec("cond", i ? COND_LINE_FAIL : COND_NORMAL, cond);
      line_trip = 1'b0;
    end
    $display("test fuses done");
  endtask : t_fuses

  initial begin
    mag = '0;
    rot = ROT_POS;
    slip = 1'b0;
    bus_trip = 1'b0;
    line_trip = 1'b0;
    block_i = 1'b0;
    set_s = '{LOW_PICKUP_RST, HIGH_DETECT_RST, ANGLE_LIMIT_RST, 1'b1, 1'b1,
              19'h00003};
    t_reset();
    t_sequence();
    t_thresholds();
    t_timer();
    t_block();
    t_fuses();
    complete_run();
  end
endmodule : testbench

// ==== testbench/vt_front_end.sv ====
// Purpose: Front end model, four voltage channels and fuse pins
// Assumes: Three phase magnitudes, rotation and slip are commanded by the bench
// Notes: Slip advances all angles together once per update period

`timescale 1ns/1ps

module vt_front_end
  import vts_pkg::*;
#(
  parameter int PERIOD = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Commands
  input wire logic [NPH-1:0][MAG_W-1:0] mag_i,
  input wire rotation_type rot_i,
  input wire logic slip_i,
  input wire logic bus_trip_i,
  input wire logic line_trip_i,
  // Far side pins
  output chan_type [NCH-1:0] chans_o,
  output logic bus_pin_o,
  output logic line_pin_o
);
  logic [ANG_W-1:0] base_q;
  logic [ANG_W-1:0] off2;
  logic [ANG_W-1:0] off3;
  int cnt_q;

  // ****************************************
  // Refresh once per period
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 0;
      base_q <= 12'h000;
    end else if (cnt_q == PERIOD - 1) begin
      cnt_q <= 0;
      if (slip_i) begin
        base_q <= (base_q + 12'h064) % FULL_TURN;
      end
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end

  always_comb begin
    off2 = (rot_i == ROT_POS) ? TWO_THIRD_TURN :
           (rot_i == ROT_NEG) ? THIRD_TURN : 12'h000;
    off3 = (rot_i == ROT_POS) ? THIRD_TURN :
           (rot_i == ROT_NEG) ? TWO_THIRD_TURN : 12'h000;
    chans_o[0] = '{mag: mag_i[0], ang: base_q};
    chans_o[1].mag = mag_i[1];
    chans_o[1].ang = ANG_W'((int'(base_q) + int'(off2)) % int'(FULL_TURN));
    chans_o[2].mag = mag_i[2];
    chans_o[2].ang = ANG_W'((int'(base_q) + int'(off3)) % int'(FULL_TURN));
    chans_o[3] = '{mag: 10'h064, ang: base_q};
  end

  assign bus_pin_o = bus_trip_i;
  assign line_pin_o = line_trip_i;
endmodule : vt_front_end
